// ===== bench/tape_mode_parameter_control_tb.sv
// Self-checking bench for the tape mode parameter block
`timescale 1ns/10ps
`default_nettype none
module tape_mode_parameter_control_tb;
   logic clk, resetn, sel_wr, sns_rd, four_byte_opt, cart_inserted, cmd_start, cmd_is_write;
   logic [5:0] sel_page, sns_page;
   logic [3:0] sel_addr, sns_addr;
   logic [7:0] sel_wdata, buf_fill, buf_free, sns_data_ff;
   logic [23:0] cmd_len, cmd_block;
   logic wr_active, rd_active, buf_empty, gap_written, track_end, gap_track_done, bad_block;
   logic sns_valid_ff, sns_hit_ff, may_disconnect_ff, parity_check_ff, auto_thread_ff;
   logic [1:0] cart_expect_ff, disc_align_ff;
   logic len_err_ff, xfer_go_ff, motion_go_ff, reconnect_ff, write_gap_ff, finish_track_ff;
   logic gap_track_ff, motion_stop_ff, reread_normal_ff, reread_slow_ff, rewrite_allowed_ff;
   int n_mismatch = 0, checks = 0, cyc = 0, cnt_go = 0, cnt_err = 0, cnt_norm = 0, cnt_slow = 0;
   wire [3:0] gap_vec = {write_gap_ff, finish_track_ff, gap_track_ff, motion_stop_ff};

   tmpc_top dut (.clk, .resetn, .sel_wr, .sel_page, .sel_addr, .sel_wdata, .sns_rd, .sns_page,
      .sns_addr, .four_byte_opt, .cart_inserted, .cmd_start, .cmd_is_write, .cmd_len,
      .cmd_block, .wr_active, .rd_active, .buf_fill, .buf_free, .buf_empty, .gap_written,
      .track_end, .gap_track_done, .bad_block, .sns_data_ff, .sns_valid_ff, .sns_hit_ff,
      .cart_expect_ff, .may_disconnect_ff, .disc_align_ff, .parity_check_ff, .auto_thread_ff,
      .len_err_ff, .xfer_go_ff, .motion_go_ff, .reconnect_ff, .write_gap_ff, .finish_track_ff,
      .gap_track_ff, .motion_stop_ff, .reread_normal_ff, .reread_slow_ff, .rewrite_allowed_ff);
   tmpc_initiator ini (.clk, .sns_data_ff, .sns_valid_ff, .sel_wr, .sel_page, .sel_addr,
      .sel_wdata, .sns_rd, .sns_page, .sns_addr, .cmd_start, .cmd_is_write, .cmd_len, .cmd_block);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Count pulses to judge their number
   always @(posedge clk) begin
      cyc <= cyc + 1;
      cnt_go <= cnt_go + (xfer_go_ff === 1'b1);
      cnt_err <= cnt_err + (len_err_ff === 1'b1);
      cnt_norm <= cnt_norm + (reread_normal_ff === 1'b1);
      cnt_slow <= cnt_slow + (reread_slow_ff === 1'b1);
      if (cyc == 4000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task sn(input logic [5:0] pg, input logic [3:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      ini.get_sense(pg, ad, d, v);
      chk(8'(v), 8'h01, "valid");
      chk(d, exp, $sformatf("page %h byte %h", pg, ad));
   endtask
   task cmd_expect(input logic w, input logic [23:0] len, input logic [23:0] blk,
      input int go, input int err);
      {cnt_go, cnt_err} = 0;
      ini.issue(w, len, blk);
      step(4);
      chk(8'(cnt_go), 8'(go), "starts");
      chk(8'(cnt_err), 8'(err), "errors");
   endtask
   task gap_wait(input logic [3:0] exp);
      for (int i = 0; i < 4; i++)
         if (gap_vec !== exp) step(1);
      chk(8'(gap_vec), 8'(exp), "gap state");
   endtask
   task bad_expect(input int nrm, input int slw);
      {cnt_norm, cnt_slow} = 0;
      bad_block = 1'b1;
      step(1);
      bad_block = 1'b0;
      step(3);
      chk(8'(cnt_norm), 8'(nrm), "normal");
      chk(8'(cnt_slow), 8'(slw), "slow");
   endtask

   // Power-on values
   task t_defaults();
      sn(6'h00, 4'h0, 8'h0a);
      sn(6'h00, 4'h2, 8'h80);
      sn(6'h00, 4'h3, 8'h80);
      sn(6'h00, 4'h4, 8'h07);
      sn(6'h01, 4'h0, 8'h01);
      sn(6'h3f, 4'h1, 8'h07);
      sn(6'h01, 4'h2, 8'h00);
      sn(6'h01, 4'h3, 8'h0b);
      sn(6'h01, 4'h8, 8'h0b);
      chk(8'(may_disconnect_ff), 8'h01, "may disconnect");
      chk(8'(parity_check_ff), 8'h01, "parity on");
      chk(8'(rewrite_allowed_ff), 8'h01, "rewrite on");
   endtask
   // Option bits, read-only and unknown places
   task t_options();
      four_byte_opt = 1'b1;
      cart_inserted = 1'b1;
      ini.put_param(6'h00, 4'h0, 8'hff);
      sn(6'h00, 4'h0, 8'haf);
      chk(8'(cart_expect_ff), 8'h01, "size unknown");
      chk(8'(may_disconnect_ff), 8'h00, "stay");
      chk(8'(disc_align_ff), 8'h03, "four byte");
      chk(8'(auto_thread_ff), 8'h00, "thread off");
      sn(6'h00, 4'h3, 8'ha0);
      ini.put_param(6'h00, 4'h1, 8'h01);
      sn(6'h00, 4'h1, 8'h01);
      chk(8'(cart_expect_ff), 8'h02, "long cartridge");
      four_byte_opt = 1'b0;
      ini.put_param(6'h00, 4'h0, 8'h04);
      sn(6'h00, 4'h0, 8'h0c);
      chk(8'(disc_align_ff), 8'h01, "two byte");
      chk(8'(parity_check_ff), 8'h00, "parity off");
      chk(8'(auto_thread_ff), 8'h01, "thread on");
      chk(8'(cart_expect_ff), 8'h02, "long wins");
      ini.put_param(6'h01, 4'h0, 8'hff);
      sn(6'h01, 4'h0, 8'h01);
      sn(6'h05, 4'h0, 8'h00);
      chk(8'(sns_hit_ff), 8'h00, "page miss");
      ini.put_param(6'h00, 4'h0, 8'h02);
   endtask
   // Motion and reconnect levels
   task t_levels();
      ini.put_param(6'h00, 4'h2, 8'h10);
      sn(6'h00, 4'h2, 8'h20);
      ini.put_param(6'h00, 4'h2, 8'h40);
      ini.put_param(6'h00, 4'h3, 8'h50);
      sn(6'h02, 4'h2, 8'h50);
      sn(6'h02, 4'h3, 8'h50);
      {wr_active, buf_fill, buf_free} = {1'b1, 8'h3f, 8'h4f};
      step(2);
      chk(8'({motion_go_ff, reconnect_ff}), 8'h00, "write below");
      {buf_fill, buf_free} = {8'h40, 8'h50};
      step(2);
      chk(8'({motion_go_ff, reconnect_ff}), 8'h03, "write at");
      {wr_active, rd_active, buf_fill} = {1'b0, 1'b1, 8'h41};
      step(2);
      chk(8'({motion_go_ff, reconnect_ff}), 8'h00, "read between");
      buf_fill = 8'h50;
      step(2);
      chk(8'({motion_go_ff, reconnect_ff}), 8'h01, "read full");
      rd_active = 1'b0;
   endtask
   // Size limits and held-off transfers
   task t_command();
      {buf_fill, buf_free} = {8'h00, 8'hff};
      cmd_expect(1'b1, 24'h001000, 24'h03c000, 1, 0);
      cmd_expect(1'b0, 24'h001000, 24'h03c001, 0, 1);
      ini.put_param(6'h00, 4'h0, 8'h22);
      cmd_expect(1'b1, 24'h028001, 24'h000400, 0, 1);
      cmd_expect(1'b0, 24'h010000, 24'h028001, 0, 1);
      buf_free = 8'h07;
      cmd_expect(1'b1, 24'h008000, 24'h000400, 0, 0);
      buf_free = 8'h08;
      step(4);
      chk(8'(cnt_go), 8'h01, "write go");
      cmd_expect(1'b0, 24'h008000, 24'h000400, 0, 0);
      buf_fill = 8'h08;
      step(4);
      chk(8'(cnt_go), 8'h01, "read go");
      buf_free = 8'h28;
      cmd_expect(1'b1, 24'h028000, 24'h028000, 1, 0);
      ini.put_param(6'h00, 4'h0, 8'h02);
   endtask
   // Gap blocks, track finish, gap track, stop
   task t_gap();
      ini.put_param(6'h00, 4'h4, 8'h02);
      {wr_active, buf_empty} = 2'b11;
      gap_wait(4'b1000);
      gap_written = 1'b1;
      step(1);
      gap_written = 1'b0;
      step(3);
      chk(8'(gap_vec), 8'h08, "one gap");
      gap_written = 1'b1;
      step(1);
      gap_written = 1'b0;
      gap_wait(4'b0100);
      track_end = 1'b1;
      step(1);
      track_end = 1'b0;
      gap_wait(4'b0010);
      gap_track_done = 1'b1;
      step(1);
      gap_track_done = 1'b0;
      gap_wait(4'b0001);
      {wr_active, buf_empty} = 2'b00;
      gap_wait(4'b0000);
   endtask
   // Reread counts and write retry values
   task t_retry();
      bad_expect(1, 1);
      sn(6'h01, 4'h3, 8'h02);
      ini.put_param(6'h01, 4'h3, 8'h01);
      bad_expect(1, 0);
      ini.put_param(6'h01, 4'h3, 8'h00);
      bad_expect(0, 0);
      ini.put_param(6'h01, 4'h8, 8'h00);
      sn(6'h01, 4'h8, 8'h00);
      chk(8'(rewrite_allowed_ff), 8'h00, "no rewrite");
      ini.put_param(6'h01, 4'h8, 8'h05);
      sn(6'h01, 4'h8, 8'h0b);
   endtask

   initial begin
      {resetn, four_byte_opt, cart_inserted, wr_active, rd_active, buf_empty} = 6'h00;
      {gap_written, track_end, gap_track_done, bad_block, buf_fill, buf_free} = 20'h0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      t_defaults();
      t_options();
      t_levels();
      t_command();
      t_gap();
      t_retry();
      tally_and_finish();
   end
endmodule // tape_mode_parameter_control_tb
`default_nettype wire

// ===== bench/tmpc_assertions.sv
// Port checker for the tape mode parameter block
`timescale 1ns/10ps
`default_nettype none
module tmpc_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sel_wr,
   input wire logic sns_rd,
   input wire logic [5:0] sns_page,
   input wire logic [3:0] sns_addr,
   input wire logic cmd_start,
   input wire logic [23:0] cmd_len,
   input wire logic [23:0] cmd_block,
   input wire logic bad_block,
   input wire logic [7:0] sns_data_ff,
   input wire logic sns_valid_ff,
   input wire logic may_disconnect_ff,
   input wire logic len_err_ff,
   input wire logic xfer_go_ff,
   input wire logic gap_track_ff,
   input wire logic motion_stop_ff,
   input wire logic reread_normal_ff,
   input wire logic reread_slow_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Answer lands after the take edge
   a_recov_code: assert property (
      sns_rd && sns_page == 6'h01 && sns_addr == 4'h0 |=> sns_valid_ff && sns_data_ff == 8'h01)
      else $error("recovery page code wrong");
   a_recov_len: assert property (
      sns_rd && (sns_page == 6'h01 || sns_page == 6'h3f) && sns_addr == 4'h1
      |=> sns_data_ff == 8'h07) else $error("recovery page length wrong");
   a_unsup_flags: assert property (
      sns_rd && (sns_page == 6'h01 || sns_page == 6'h3f) && sns_addr == 4'h2
      |=> sns_data_ff == 8'h00) else $error("unsupported flags set");
   a_legacy_busy: assert property (
      sns_rd && sns_page == 6'h00 && sns_addr == 4'h0 |=> sns_data_ff[3])
      else $error("legacy busy bit reads zero");
   // Flag lags a select; skip that cycle
   a_block_limit: assert property (
      cmd_start && may_disconnect_ff && !$past(sel_wr) && cmd_block > 24'h03c000
      |=> len_err_ff && !xfer_go_ff) else $error("oversize block not refused");
   a_block_pass: assert property (
      cmd_start && may_disconnect_ff && !$past(sel_wr) && cmd_block <= 24'h03c000
      |=> xfer_go_ff && !len_err_ff) else $error("legal block not started");
   a_stay_limit: assert property (
      cmd_start && !may_disconnect_ff && !$past(sel_wr)
      && (cmd_len > 24'h028000 || cmd_block > 24'h028000)
      |=> len_err_ff && !xfer_go_ff) else $error("oversize stay not refused");
   a_slow_pairs: assert property (
      reread_slow_ff |-> reread_normal_ff) else $error("slow reread without normal one");
   a_reread_cause: assert property (
      reread_normal_ff |-> $past(bad_block)) else $error("reread without bad block");
   a_stop_order: assert property (
      $rose(motion_stop_ff) |-> $past(gap_track_ff)) else $error("stop before gap track");
endmodule // tmpc_checker
bind tmpc_top tmpc_checker u_chk (.clk, .resetn, .sel_wr, .sns_rd, .sns_page, .sns_addr,
   .cmd_start, .cmd_len, .cmd_block, .bad_block, .sns_data_ff, .sns_valid_ff,
   .may_disconnect_ff, .len_err_ff, .xfer_go_ff, .gap_track_ff, .motion_stop_ff,
   .reread_normal_ff, .reread_slow_ff);
`default_nettype wire

// ===== bench/tmpc_initiator.sv
// Host adapter model issuing select, sense and transfer commands
`timescale 1ns/10ps
`default_nettype none
module tmpc_initiator (
   input wire logic clk,
   input wire logic [7:0] sns_data_ff,
   input wire logic sns_valid_ff,
   output logic sel_wr,
   output logic [5:0] sel_page,
   output logic [3:0] sel_addr,
   output logic [7:0] sel_wdata,
   output logic sns_rd,
   output logic [5:0] sns_page,
   output logic [3:0] sns_addr,
   output logic cmd_start,
   output logic cmd_is_write,
   output logic [23:0] cmd_len,
   output logic [23:0] cmd_block
);
   initial begin
      {sel_wr, sel_page, sel_addr, sel_wdata} = 19'h0;
      {sns_rd, sns_page, sns_addr} = 11'h0;
      {cmd_start, cmd_is_write, cmd_len, cmd_block} = 50'h0;
   end
   // Released write data shows inverse; page and address keep their value
   task put_param(input logic [5:0] pg, input logic [3:0] ad, input logic [7:0] d);
      @(negedge clk);
      {sel_wr, sel_page, sel_addr, sel_wdata} = {1'b1, pg, ad, d};
      @(negedge clk);
      {sel_wr, sel_wdata} = {1'b0, ~d};
   endtask
   // Data taken a falling edge after the take edge
   task get_sense(input logic [5:0] pg, input logic [3:0] ad, output logic [7:0] d,
      output logic v);
      @(negedge clk);
      {sns_rd, sns_page, sns_addr} = {1'b1, pg, ad};
      @(negedge clk);
      {sns_rd, sns_page} = {1'b0, ~pg};
      d = sns_data_ff;
      v = sns_valid_ff;
   endtask
   task issue(input logic w, input logic [23:0] len, input logic [23:0] blk);
      @(negedge clk);
      {cmd_start, cmd_is_write, cmd_len, cmd_block} = {1'b1, w, len, blk};
      @(negedge clk);
      {cmd_start, cmd_len, cmd_block} = {1'b0, ~len, ~blk};
   endtask
endmodule // tmpc_initiator
`default_nettype wire

// ===== logic/tmpc_defines.vh
// Constants for the tape mode parameter control block
`ifndef TMPC_DEFINES_VH
`define TMPC_DEFINES_VH
// Page codes
`define TMPC_PG_VENDOR 6'h00
`define TMPC_PG_RECOV 6'h01
`define TMPC_PG_DISC 6'h02
`define TMPC_PG_ALL 6'h3f
// Vendor block byte offsets
`define TMPC_OFF_DRV_OPT 4'h0
`define TMPC_OFF_CART_LEN 4'h1
`define TMPC_OFF_MOTION 4'h2
`define TMPC_OFF_RECON 4'h3
`define TMPC_OFF_GAP 4'h4
// Recovery page byte offsets
`define TMPC_OFF_RP_HDR 4'h0
`define TMPC_OFF_RP_LEN 4'h1
`define TMPC_OFF_RP_OPT 4'h2
`define TMPC_OFF_RD_RETRY 4'h3
`define TMPC_OFF_WR_RETRY 4'h8
// Disconnect page bytes that mirror the reconnect level
`define TMPC_OFF_DP_FULL 4'h2
`define TMPC_OFF_DP_EMPTY 4'h3
`define TMPC_DP_LEN 8'h0a
// Option byte bit positions
`define TMPC_B_CART_KIND 7
`define TMPC_B_STAY_CONN 5
`define TMPC_B_LEG_BUSY 3
`define TMPC_B_EVEN_DISC 2
`define TMPC_B_PARITY 1
`define TMPC_B_AUTO_INH 0
`define TMPC_B_LONG_CART 0
// Reset values
`define TMPC_RST_MOTION 8'h80
`define TMPC_RST_RECON 8'h80
`define TMPC_RST_GAP 8'h07
`define TMPC_RST_RD_RETRY 8'h0b
`define TMPC_RST_WR_RETRY 8'h0b
`define TMPC_RP_LEN 8'h07
// Threshold limits, 4 KByte units
`define TMPC_THR_MIN 8'h20
`define TMPC_THR_MAX 8'hd0
`define TMPC_ND_RECON_LO 8'ha0
`define TMPC_ND_RECON_HI 8'hc0
`define TMPC_GAP_MAX 8'h07
// Transfer limits in bytes
`define TMPC_MAX_BLK_DISC 24'h03c000
`define TMPC_MAX_XFER_ND 24'h028000
// Read retry encodings
`define TMPC_RETRY_NONE 8'h00
`define TMPC_RETRY_ONE 8'h01
`define TMPC_RETRY_TWO 8'h02
`endif

// ===== logic/tmpc_top.v
// Tape mode parameter store and threshold logic
// Summary of operation
// - Vendor block only at page code zero
// - Cartridge expectation, long flag overrides
// - Stay-connected flag forbids disconnect, resets 0
// - Block limit 240K when disconnect allowed
// - Stay-connected limits transfer and block 160K
// - Stay-connected write waits for full space
// - Stay-connected read waits for all data
// - Stay-connected forces a reconnect level outside A0h..C0h to A0h
// - Legacy busy flag reads one, writes ignored
// - Even boundary picks two or four bytes
// - Parity check enable, resets to one
// - Auto thread unless inhibited, resets 0
// - Motion level 4K units, 20h..D0h, 80h
// - Motion starts at fill or drain level
// - Reconnect on free space or fill level
// - Gap blocks bounded by gap limit
// - Finish track then one gap track
// - Recovery page code 01h, length 07h
// - Unsupported recovery flags read zero
// - Retry count 0/1/2 selects rereads
// - First bad block sets count to 02h
// - Write retry 00h or 0Bh; zero never rewrites
// - Paged ratios mirror reconnect level
`timescale 1ns/10ps
`default_nettype none
`include "tmpc_defines.vh"
module tmpc_top (
   input wire clk,
   input wire resetn,
   input wire sel_wr,
   input wire [5:0] sel_page,
   input wire [3:0] sel_addr,
   input wire [7:0] sel_wdata,
   input wire sns_rd,
   input wire [5:0] sns_page,
   input wire [3:0] sns_addr,
   input wire four_byte_opt,
   input wire cart_inserted,
   input wire cmd_start,
   input wire cmd_is_write,
   input wire [23:0] cmd_len,
   input wire [23:0] cmd_block,
   input wire wr_active,
   input wire rd_active,
   input wire [7:0] buf_fill,
   input wire [7:0] buf_free,
   input wire buf_empty,
   input wire gap_written,
   input wire track_end,
   input wire gap_track_done,
   input wire bad_block,
   output reg [7:0] sns_data_ff,
   output reg sns_valid_ff,
   output reg sns_hit_ff,
   output reg [1:0] cart_expect_ff,
   output reg may_disconnect_ff,
   output reg [1:0] disc_align_ff,
   output reg parity_check_ff,
   output reg auto_thread_ff,
   output reg len_err_ff,
   output reg xfer_go_ff,
   output reg motion_go_ff,
   output reg reconnect_ff,
   output reg write_gap_ff,
   output reg finish_track_ff,
   output reg gap_track_ff,
   output reg motion_stop_ff,
   output reg reread_normal_ff,
   output reg reread_slow_ff,
   output reg rewrite_allowed_ff
);
   // Gap sequencer states
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_GAP = 5'h02;
   localparam [4:0] S_FIN = 5'h04;
   localparam [4:0] S_TRK = 5'h08;
   localparam [4:0] S_STOP = 5'h10;

   reg cart_kind_flag_ff;
   reg long_cartridge_flag_ff;
   reg stay_connected_flag_ff;
   reg even_boundary_disconnect_ff;
   reg bus_parity_check_enable_ff;
   reg auto_thread_inhibit_ff;
   reg [7:0] motion_ff;
   reg [7:0] recon_ff;
   reg [7:0] gap_lim_ff;
   reg [7:0] rd_retry_ff;
   reg [7:0] wr_retry_ff;
   reg [4:0] state_ff;
   reg [7:0] gap_cnt_ff;
   reg pend_ff;
   reg pend_wr_ff;
   reg [23:0] pend_len_ff;
   reg [4:0] nxt_state;
   reg [7:0] nxt_gap_cnt;
   reg [7:0] nxt_recon;
   reg [7:0] nxt_motion;
   reg [7:0] nxt_sns;
   reg nxt_hit;
   reg [7:0] opt_byte;

   wire sel_vnd = sel_wr && (sel_page == `TMPC_PG_VENDOR);
   wire sel_rp = sel_wr && (sel_page == `TMPC_PG_RECOV);
   wire sel_dp = sel_wr && (sel_page == `TMPC_PG_DISC);
   // Buffer levels in bytes
   wire [23:0] fill_bytes = {4'h0, buf_fill, 12'h000};
   wire [23:0] free_bytes = {4'h0, buf_free, 12'h000};

   // Clamp threshold to legal window
   function [7:0] clamp_thr;
      input [7:0] v;
      begin
         if (v < `TMPC_THR_MIN) begin
            clamp_thr = `TMPC_THR_MIN;
         end else if (v > `TMPC_THR_MAX) begin
            clamp_thr = `TMPC_THR_MAX;
         end else begin
            clamp_thr = v;
         end
      end
   endfunction

   // Threshold next values
   always @* begin
      nxt_motion = motion_ff;
      nxt_recon = recon_ff;
      if (sel_vnd && sel_addr == `TMPC_OFF_MOTION) begin
         nxt_motion = clamp_thr(sel_wdata);
      end
      if (sel_vnd && sel_addr == `TMPC_OFF_RECON) begin
         nxt_recon = clamp_thr(sel_wdata);
      end
      if (sel_dp && (sel_addr == `TMPC_OFF_DP_FULL || sel_addr == `TMPC_OFF_DP_EMPTY)) begin
         nxt_recon = clamp_thr(sel_wdata);
      end
      if (stay_connected_flag_ff &&
          (nxt_recon < `TMPC_ND_RECON_LO || nxt_recon > `TMPC_ND_RECON_HI)) begin
         nxt_recon = `TMPC_ND_RECON_LO;
      end
   end

   // Parameter store
   always @(posedge clk) begin
      if (!resetn) begin
         cart_kind_flag_ff <= 1'b0;
         long_cartridge_flag_ff <= 1'b0;
         stay_connected_flag_ff <= 1'b0;
         even_boundary_disconnect_ff <= 1'b0;
         bus_parity_check_enable_ff <= 1'b1;
         auto_thread_inhibit_ff <= 1'b0;
         motion_ff <= `TMPC_RST_MOTION;
         recon_ff <= `TMPC_RST_RECON;
         gap_lim_ff <= `TMPC_RST_GAP;
         wr_retry_ff <= `TMPC_RST_WR_RETRY;
      end else begin
         // vendor block at page zero only
         if (sel_vnd && sel_addr == `TMPC_OFF_DRV_OPT) begin
            cart_kind_flag_ff <= sel_wdata[`TMPC_B_CART_KIND];
            stay_connected_flag_ff <= sel_wdata[`TMPC_B_STAY_CONN];
            even_boundary_disconnect_ff <= sel_wdata[`TMPC_B_EVEN_DISC];
            bus_parity_check_enable_ff <= sel_wdata[`TMPC_B_PARITY];
            auto_thread_inhibit_ff <= sel_wdata[`TMPC_B_AUTO_INH];
         end
         if (sel_vnd && sel_addr == `TMPC_OFF_CART_LEN) begin
            long_cartridge_flag_ff <= sel_wdata[`TMPC_B_LONG_CART];
         end
         if (sel_vnd && sel_addr == `TMPC_OFF_GAP) begin
            gap_lim_ff <= (sel_wdata > `TMPC_GAP_MAX) ? `TMPC_GAP_MAX : sel_wdata;
         end
         motion_ff <= nxt_motion;
         recon_ff <= nxt_recon;
         if (sel_rp && sel_addr == `TMPC_OFF_WR_RETRY) begin
            wr_retry_ff <= (sel_wdata == 8'h00) ? 8'h00 : `TMPC_RST_WR_RETRY;
         end
      end
   end

   // Read retry; bad block beats same-cycle select only while count is above 02h
   always @(posedge clk) begin
      if (!resetn) begin
         rd_retry_ff <= `TMPC_RST_RD_RETRY;
         reread_normal_ff <= 1'b0;
         reread_slow_ff <= 1'b0;
      end else begin
         reread_normal_ff <= 1'b0;
         reread_slow_ff <= 1'b0;
         if (sel_rp && sel_addr == `TMPC_OFF_RD_RETRY) begin
            rd_retry_ff <= (sel_wdata > `TMPC_RST_RD_RETRY) ? `TMPC_RST_RD_RETRY : sel_wdata;
         end
         if (bad_block) begin
            // first bad block drops to two
            if (rd_retry_ff > `TMPC_RETRY_TWO) begin
               rd_retry_ff <= `TMPC_RETRY_TWO;
               reread_normal_ff <= 1'b1;
               reread_slow_ff <= 1'b1;
            end else begin
               reread_normal_ff <= (rd_retry_ff != `TMPC_RETRY_NONE);
               reread_slow_ff <= (rd_retry_ff == `TMPC_RETRY_TWO);
            end
         end
      end
   end

   // Option byte as sensed
   always @* begin
      opt_byte = 8'h00;
      opt_byte[`TMPC_B_CART_KIND] = cart_kind_flag_ff;
      opt_byte[`TMPC_B_STAY_CONN] = stay_connected_flag_ff;
      opt_byte[`TMPC_B_LEG_BUSY] = 1'b1;
      opt_byte[`TMPC_B_EVEN_DISC] = even_boundary_disconnect_ff;
      opt_byte[`TMPC_B_PARITY] = bus_parity_check_enable_ff;
      opt_byte[`TMPC_B_AUTO_INH] = auto_thread_inhibit_ff;
   end

   // Sense mux; unknown page gives zero, no hit
   always @* begin
      nxt_sns = 8'h00;
      nxt_hit = 1'b0;
      if (sns_page == `TMPC_PG_VENDOR) begin
         nxt_hit = 1'b1;
         case (sns_addr)
            `TMPC_OFF_DRV_OPT: begin
               nxt_sns = opt_byte;
            end
            `TMPC_OFF_CART_LEN: begin
               nxt_sns = {7'h00, long_cartridge_flag_ff};
            end
            `TMPC_OFF_MOTION: begin
               nxt_sns = motion_ff;
            end
            `TMPC_OFF_RECON: begin
               nxt_sns = recon_ff;
            end
            `TMPC_OFF_GAP: begin
               nxt_sns = gap_lim_ff;
            end
            default: begin
               nxt_hit = 1'b0;
            end
         endcase
      // recovery page for 01h or 3Fh
      end else if (sns_page == `TMPC_PG_RECOV || sns_page == `TMPC_PG_ALL) begin
         nxt_hit = 1'b1;
         case (sns_addr)
            `TMPC_OFF_RP_HDR: begin
               nxt_sns = {2'b00, `TMPC_PG_RECOV};
            end
            `TMPC_OFF_RP_LEN: begin
               nxt_sns = `TMPC_RP_LEN;
            end
            `TMPC_OFF_RP_OPT: begin
               nxt_sns = 8'h00;
            end
            `TMPC_OFF_RD_RETRY: begin
               nxt_sns = rd_retry_ff;
            end
            `TMPC_OFF_WR_RETRY: begin
               nxt_sns = wr_retry_ff;
            end
            default: begin
               nxt_sns = 8'h00;
            end
         endcase
      end else if (sns_page == `TMPC_PG_DISC) begin
         nxt_hit = 1'b1;
         case (sns_addr)
            4'h0: begin
               nxt_sns = {2'b00, `TMPC_PG_DISC};
            end
            4'h1: begin
               nxt_sns = `TMPC_DP_LEN;
            end
            `TMPC_OFF_DP_FULL, `TMPC_OFF_DP_EMPTY: begin
               nxt_sns = recon_ff;
            end
            default: begin
               nxt_sns = 8'h00;
            end
         endcase
      end
   end

   // Sense answer next cycle, held to next request
   always @(posedge clk) begin
      if (!resetn) begin
         sns_data_ff <= 8'h00;
         sns_valid_ff <= 1'b0;
         sns_hit_ff <= 1'b0;
      end else begin
         sns_valid_ff <= sns_rd;
         if (sns_rd) begin
            sns_data_ff <= nxt_sns;
            sns_hit_ff <= nxt_hit;
         end
      end
   end

   // Static drive controls
   always @(posedge clk) begin
      if (!resetn) begin
         cart_expect_ff <= 2'b00;
         may_disconnect_ff <= 1'b1;
         disc_align_ff <= 2'b00;
         parity_check_ff <= 1'b1;
         auto_thread_ff <= 1'b0;
      end else begin
         cart_expect_ff <= long_cartridge_flag_ff ? 2'b10 : {1'b0, cart_kind_flag_ff};
         may_disconnect_ff <= ~stay_connected_flag_ff;
         disc_align_ff <= even_boundary_disconnect_ff ? {four_byte_opt, 1'b1} : 2'b00;
         parity_check_ff <= bus_parity_check_enable_ff;
         auto_thread_ff <= cart_inserted & ~auto_thread_inhibit_ff;
      end
   end

   // Command limits and transfer start gating
   always @(posedge clk) begin
      if (!resetn) begin
         len_err_ff <= 1'b0;
         xfer_go_ff <= 1'b0;
         pend_ff <= 1'b0;
         pend_wr_ff <= 1'b0;
         pend_len_ff <= 24'h000000;
      end else begin
         len_err_ff <= 1'b0;
         xfer_go_ff <= 1'b0;
         if (cmd_start) begin
            if (stay_connected_flag_ff) begin
               if (cmd_len > `TMPC_MAX_XFER_ND || cmd_block > `TMPC_MAX_XFER_ND) begin
                  len_err_ff <= 1'b1;
               end else begin
                  pend_ff <= 1'b1;
                  pend_wr_ff <= cmd_is_write;
                  pend_len_ff <= cmd_len;
               end
            end else if (cmd_block > `TMPC_MAX_BLK_DISC) begin
               len_err_ff <= 1'b1;
            end else begin
               xfer_go_ff <= 1'b1;
            end
         end else if (pend_ff) begin
            if (pend_wr_ff && free_bytes >= pend_len_ff) begin
               xfer_go_ff <= 1'b1;
               pend_ff <= 1'b0;
            end
            if (!pend_wr_ff && fill_bytes >= pend_len_ff) begin
               xfer_go_ff <= 1'b1;
               pend_ff <= 1'b0;
            end
         end
      end
   end

   // Level compares
   always @(posedge clk) begin
      if (!resetn) begin
         motion_go_ff <= 1'b0;
         reconnect_ff <= 1'b0;
      end else begin
         // fill on write, drain on read
         motion_go_ff <= (wr_active && buf_fill >= motion_ff) ||
                         (rd_active && buf_fill <= motion_ff);
         reconnect_ff <= (wr_active && buf_free >= recon_ff) ||
                         (rd_active && buf_fill >= recon_ff);
      end
   end

   // Gap sequencer next state
   always @* begin
      nxt_state = state_ff;
      nxt_gap_cnt = gap_cnt_ff;
      case (state_ff)
         S_IDLE: begin
            nxt_gap_cnt = 8'h00;
            if (wr_active && buf_empty) begin
               nxt_state = S_GAP;
            end
         end
         S_GAP: begin
            if (gap_cnt_ff >= gap_lim_ff) begin
               nxt_state = buf_empty ? S_FIN : S_IDLE;
            end else if (gap_written) begin
               nxt_gap_cnt = gap_cnt_ff + 8'h01;
            end
         end
         S_FIN: begin
            if (track_end) begin
               nxt_state = S_TRK;
            end
         end
         S_TRK: begin
            if (gap_track_done) begin
               nxt_state = S_STOP;
            end
         end
         S_STOP: begin
            if (!wr_active) begin
               nxt_state = S_IDLE;
            end
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   // Gap sequencer registers and outputs
   always @(posedge clk) begin
      if (!resetn) begin
         state_ff <= S_IDLE;
         gap_cnt_ff <= 8'h00;
         write_gap_ff <= 1'b0;
         finish_track_ff <= 1'b0;
         gap_track_ff <= 1'b0;
         motion_stop_ff <= 1'b0;
         rewrite_allowed_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         gap_cnt_ff <= nxt_gap_cnt;
         write_gap_ff <= (nxt_state == S_GAP);
         finish_track_ff <= (nxt_state == S_FIN);
         gap_track_ff <= (nxt_state == S_TRK);
         motion_stop_ff <= (nxt_state == S_STOP);
         rewrite_allowed_ff <= (wr_retry_ff != 8'h00);
      end
   end
endmodule // tmpc_top
`default_nettype wire
